// File: core/mswd_top.sv
// Three four-stage watchdogs behind an Avalon-MM slave with interrupt and reset requests.
//
// Notes on behaviour
// - Two main watchdogs plus one always-on watchdog.
// - Four stages, each configurable or disabled.
// - Expired enabled stage performs its one action.
// - Feeding or disabling first prevents stage action.
// - System reset only from the always-on watchdog.
// - Own timeout per stage, 32-bit counter.
// - Flash boot auto-starts always-on and first main.
// - Unfinished flash boot reboots the whole system.
// - Configuration is write-protected against stray writes.
`timescale 1ns/1ps
`include "mswd_cfg.svh"
module mswd_top
    import mswd_pkg::*;
#(
    parameter int unsigned BOOT_TMO_CYC = `MSWD_BOOT_CYC
) (
    // Clock and reset.
    input  wire logic        CLK,
    input  wire logic        RESET,
    // Avalon-MM register slave.
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    // Boot strap pin, high when booting from flash.
    input  wire logic        BOOT_FLASH,
    // Interrupt and reset requests.
    output logic             IRQ,
    output logic             CPU_RST_REQ,
    output logic             CORE_RST_REQ,
    output logic             SYS_RST_REQ
);
    localparam int NW  = 3;
    localparam int AON = 2;

    // Elaboration check on the boot guard length.
    if (BOOT_TMO_CYC < 1) begin : g_bad_boot
        $error("BOOT_TMO_CYC must be at least one cycle.");
    end

    logic [`MSWD_CFG_W-1:0] cfg_q  [NW];
    logic [31:0]            tmo_q  [NW][4];
    logic [NW-1:0]          lock_q;
    logic [NW-1:0]          feed_q;
    logic [NW-1:0]          int_st_q;
    logic [NW-1:0]          int_en_q;
    logic [1:0]             boot_cnt_q;
    logic                   boot_seen_q;
    logic                   boot_flash_s;
    logic                   wr_go;
    logic                   rd_go;
    logic [1:0]             blk;
    logic [5:0]             off;
    logic [31:0]            rd_d;

    // Per-instance state seen by the register file.
    mswd_st_t               st_w   [NW];
    logic [1:0]             stg_w  [NW];
    logic [31:0]            cnt_w  [NW];
    logic [NW-1:0]          fire_w;
    mswd_act_t              fact_w [NW];

    // Merges write data into a word under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Strap pin crosses into the clock domain before anything reads it.
    mswd_sync #(
        .W (1)
    ) u_boot_sync (
        .clk   (CLK),
        .reset (RESET),
        .d     (BOOT_FLASH),
        .q     (boot_flash_s)
    );

    // Address split, the edge at which a write completes and the edge at which read data is taken.
    assign blk   = AVS_ADDRESS[7:6];
    assign off   = AVS_ADDRESS[5:0];
    assign wr_go = AVS_WRITE && !AVS_WAITREQUEST;
    assign rd_go = AVS_READ && AVS_WAITREQUEST;

    // One wait cycle per access: waitrequest drops for exactly one cycle.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
        end
    end

    // Boot capture waits for the synchroniser to settle after reset.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            boot_cnt_q  <= 2'h0;
            boot_seen_q <= 1'b0;
        end else if (boot_cnt_q != `MSWD_BOOT_WAIT) begin
            boot_cnt_q <= boot_cnt_q + 2'h1;
        end else begin
            boot_seen_q <= 1'b1;
        end
    end

    for (genvar w = 0; w < NW; w++) begin : g_wdt
        logic [11:0]  acts;
        logic [127:0] tmos;
        logic         boot_arm;
        logic         sel;
        logic [31:0]  cfg_merged;

        assign acts = cfg_q[w][`MSWD_CFG_ACT_LSB +: 12];
        assign tmos = {tmo_q[w][3], tmo_q[w][2], tmo_q[w][1], tmo_q[w][0]};
        assign sel  = (blk == 2'(w));
        assign boot_arm = (w == 0 || w == AON) && boot_flash_s
                          && !boot_seen_q && boot_cnt_q == `MSWD_BOOT_WAIT;

        always_ff @(posedge CLK) begin
            if (RESET) begin
                lock_q[w] <= 1'b1;
            end else if (wr_go && sel && off == `MSWD_OFF_PROT) begin
                lock_q[w] <= (AVS_WRITEDATA != `MSWD_UNLOCK_KEY);
            end
        end

        // Byte-lane merge of a configuration write; bits above the word are dropped.
        assign cfg_merged = merge(32'(cfg_q[w]), AVS_WRITEDATA, AVS_BYTEENABLE);

        always_ff @(posedge CLK) begin
            if (RESET) begin
                cfg_q[w] <= `MSWD_CFG_RST;
            end else if (boot_arm) begin
                cfg_q[w] <= (w == AON) ? `MSWD_CFG_BOOT_AO : `MSWD_CFG_BOOT_MN;
            end else if (wr_go && sel && off == `MSWD_OFF_CFG && !lock_q[w]) begin
                cfg_q[w] <= cfg_merged[`MSWD_CFG_W-1:0];
            end
        end

        // boot guard period on stage one
        for (genvar s = 0; s < 4; s++) begin : g_tmo
            always_ff @(posedge CLK) begin
                if (RESET) begin
                    tmo_q[w][s] <= `MSWD_TMO_RST;
                end else if (boot_arm && s == 0) begin
                    tmo_q[w][s] <= 32'(BOOT_TMO_CYC);
                end else if (wr_go && sel && !lock_q[w]
                             && off == `MSWD_OFF_TMO0 + 6'(4 * s)) begin
                    tmo_q[w][s] <= merge(tmo_q[w][s], AVS_WRITEDATA,
                                         AVS_BYTEENABLE);
                end
            end
        end

        always_ff @(posedge CLK) begin
            if (RESET) begin
                feed_q[w] <= 1'b0;
            end else begin
                feed_q[w] <= wr_go && sel && off == `MSWD_OFF_FEED && !lock_q[w];
            end
        end

        mswd_wdt #(
            .HAS_SYS (w == AON)
        ) u_wdt (
            .clk        (CLK),
            .reset      (RESET),
            .en         (cfg_q[w][`MSWD_CFG_EN_BIT]),
            .acts       (acts),
            .tmos       (tmos),
            .feed       (feed_q[w]),
            .state_q    (st_w[w]),
            .stage_q    (stg_w[w]),
            .count_q    (cnt_w[w]),
            .fire_q     (fire_w[w]),
            .fire_act_q (fact_w[w])
        );

        // Stage interrupt sets a sticky bit; a set beats a same-cycle clear.
        always_ff @(posedge CLK) begin
            if (RESET) begin
                int_st_q[w] <= 1'b0;
            end else if (fire_w[w] && fact_w[w] == ACT_INT) begin
                int_st_q[w] <= 1'b1;
            end else if (wr_go && blk == `MSWD_BLK_GLOBAL
                         && off == `MSWD_OFF_INT_CLR && AVS_WRITEDATA[w]) begin
                int_st_q[w] <= 1'b0;
            end
        end
    end

    // Interrupt enable register.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            int_en_q <= '0;
        end else if (wr_go && blk == `MSWD_BLK_GLOBAL && off == `MSWD_OFF_INT_EN) begin
            int_en_q <= AVS_WRITEDATA[NW-1:0];
        end
    end

    // Level interrupt; it trails the status bit by one cycle.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(int_st_q & int_en_q);
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            CPU_RST_REQ  <= 1'b0;
            CORE_RST_REQ <= 1'b0;
            SYS_RST_REQ  <= 1'b0;
        end else begin
            CPU_RST_REQ  <= 1'b0;
            CORE_RST_REQ <= 1'b0;
            SYS_RST_REQ  <= fire_w[AON] && fact_w[AON] == ACT_SYS;
            for (int w = 0; w < NW; w++) begin
                if (fire_w[w] && fact_w[w] == ACT_CPU) begin
                    CPU_RST_REQ <= 1'b1;
                end
                if (fire_w[w] && fact_w[w] == ACT_CORE) begin
                    CORE_RST_REQ <= 1'b1;
                end
            end
        end
    end

    // Read mux; unmapped and write-only words read as zero.
    always_comb begin
        rd_d = 32'h0;
        if (blk == `MSWD_BLK_GLOBAL) begin
            if (off == `MSWD_OFF_INT_ST) begin
                rd_d = 32'(int_st_q);
            end else if (off == `MSWD_OFF_INT_EN) begin
                rd_d = 32'(int_en_q);
            end
        end else begin
            case (off)
                `MSWD_OFF_CFG:  rd_d = 32'(cfg_q[blk]);
                `MSWD_OFF_PROT: rd_d = 32'(lock_q[blk]);
                `MSWD_OFF_STAT: rd_d = {28'h0, st_w[blk], stg_w[blk]};
                `MSWD_OFF_CNT:  rd_d = cnt_w[blk];
                default: begin
                    if (off >= `MSWD_OFF_TMO0 && off <= `MSWD_OFF_TMO3) begin
                        rd_d = tmo_q[blk][2'(off[4:2] - 3'h1)];
                    end
                end
            endcase
        end
    end

    // Read data is caught at the first edge and stands while waitrequest is low.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            AVS_READDATA <= 32'h0;
        end else if (rd_go) begin
            AVS_READDATA <= rd_d;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    // Bus handshake: one wait cycle per access, then waitrequest is high again.
    a_wait_one: assert property (
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("Slave did not answer after one wait cycle.");
    a_wait_drop: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("Waitrequest stayed low for two cycles.");

    a_lock_cfg: assert property (
        wr_go && blk == 2'h1 && off == `MSWD_OFF_CFG && lock_q[1] |=> $stable(cfg_q[1]))
        else $error("Locked configuration changed.");
    a_lock_tmo: assert property (
        wr_go && blk == 2'h1 && off == `MSWD_OFF_TMO0 && lock_q[1]
        |=> $stable(tmo_q[1][0]))
        else $error("Locked timeout changed.");

    a_lock_feed: assert property (lock_q[1] |=> !feed_q[1])
        else $error("Feed accepted while locked.");
    a_unlock_key: assert property (
        wr_go && blk == 2'h1 && off == `MSWD_OFF_PROT && AVS_WRITEDATA == `MSWD_UNLOCK_KEY
        |=> !lock_q[1])
        else $error("Unlock key did not lift protection.");

    a_sys_only_aon: assert property (
        SYS_RST_REQ |-> $past(fire_w[AON]) && $past(fact_w[AON]) == ACT_SYS)
        else $error("System reset without always-on expiry.");

    a_boot_start: assert property (
        $rose(boot_seen_q) && $past(boot_flash_s)
        |-> cfg_q[0][0] && cfg_q[AON][0] && !cfg_q[1][0])
        else $error("Flash boot did not start the watchdogs.");
    a_boot_tmo: assert property (
        $rose(boot_seen_q) && $past(boot_flash_s)
        |-> tmo_q[0][0] == 32'(BOOT_TMO_CYC) && tmo_q[AON][0] == 32'(BOOT_TMO_CYC))
        else $error("Flash boot did not load the guard period.");

    a_core_route: assert property (fire_w[0] && fact_w[0] == ACT_CORE |=> CORE_RST_REQ)
        else $error("Core reset action not raised.");
    a_cpu_route: assert property (fire_w[1] && fact_w[1] == ACT_CPU |=> CPU_RST_REQ)
        else $error("CPU reset action not raised.");
    a_irq_level: assert property (|(int_st_q & int_en_q) |=> IRQ)
        else $error("Enabled interrupt did not raise IRQ.");
    a_irq_quiet: assert property (!(|(int_st_q & int_en_q)) |=> !IRQ)
        else $error("IRQ high with no enabled status bit.");

    // Main scenarios worth seeing in coverage.
    c_boot_sys: cover property (SYS_RST_REQ);
    c_irq: cover property ($rose(IRQ));
    c_unlock: cover property ($fell(lock_q[0]));
endmodule // mswd_top

// File: shared/mswd_cfg.svh
// Register map, field positions, reset values and timing counts of the watchdog block.
`ifndef MSWD_CFG_SVH
`define MSWD_CFG_SVH
// Address split: addr[7:6] picks a watchdog (3 = global), addr[5:0] the word.
`define MSWD_BLK_GLOBAL  2'h3
`define MSWD_OFF_CFG     6'h00
`define MSWD_OFF_TMO0    6'h04
`define MSWD_OFF_TMO3    6'h10
`define MSWD_OFF_FEED    6'h14
`define MSWD_OFF_PROT    6'h18
`define MSWD_OFF_STAT    6'h1c
`define MSWD_OFF_CNT     6'h20
`define MSWD_OFF_INT_ST  6'h00
`define MSWD_OFF_INT_EN  6'h04
`define MSWD_OFF_INT_CLR 6'h08
// Configuration word: enable bit, then one 3-bit action per stage.
`define MSWD_CFG_EN_BIT  0
`define MSWD_CFG_ACT_LSB 1
`define MSWD_CFG_W       13
`define MSWD_CFG_RST     13'h0000
`define MSWD_CFG_BOOT_MN 13'h0007
`define MSWD_CFG_BOOT_AO 13'h0009
`define MSWD_TMO_RST     32'h00ffffff
`define MSWD_UNLOCK_KEY  32'h5a5aa5a5
// Boot guard period in microseconds and the clock rate in MHz.
`define MSWD_BOOT_TMO_US 1000
`define MSWD_CLK_MHZ     200
`define MSWD_BOOT_CYC    (`MSWD_BOOT_TMO_US * `MSWD_CLK_MHZ)
`define MSWD_BOOT_WAIT   2'h3
`endif

// File: shared/mswd_pkg.sv
// Types shared by the watchdog modules.
package mswd_pkg;
    // Action taken when a stage expires; off also disables the stage.
    typedef enum logic [2:0] {
        ACT_OFF  = 3'b000,
        ACT_INT  = 3'b001,
        ACT_CPU  = 3'b010,
        ACT_CORE = 3'b011,
        ACT_SYS  = 3'b100
    } mswd_act_t;
    // Counter state of one watchdog.
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_DONE = 2'b10
    } mswd_st_t;
endpackage

// File: core/mswd_sync.sv
// Two flip-flop synchroniser for levels that arrive from pins.
`timescale 1ns/1ps
module mswd_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         reset,
    // Level in and out.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule // mswd_sync

// File: core/mswd_wdt.sv
// One four-stage watchdog counter with per-stage timeouts and actions.
`timescale 1ns/1ps
module mswd_wdt
    import mswd_pkg::*;
#(
    parameter bit HAS_SYS = 1'b0
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         reset,
    // Configuration.
    input  wire logic         en,
    input  wire logic [11:0]  acts,
    input  wire logic [127:0] tmos,
    input  wire logic         feed,
    // State and expiry events.
    output mswd_st_t          state_q,
    output logic [1:0]        stage_q,
    output logic [31:0]       count_q,
    output logic              fire_q,
    output mswd_act_t         fire_act_q
);
    logic [2:0]  act_a [4];
    logic [31:0] tmo_a [4];
    mswd_act_t   act_eff;
    logic        expire;

    // Unpack the per-stage fields.
    for (genvar s = 0; s < 4; s++) begin : g_stage
        assign act_a[s] = acts[s*3 +: 3];
        assign tmo_a[s] = tmos[s*32 +: 32];
    end

    // no system reset in main instances
    always_comb begin
        act_eff = mswd_act_t'(act_a[stage_q]);
        if (!HAS_SYS && act_eff == ACT_SYS) begin
            act_eff = ACT_OFF;
        end
    end

    assign expire = (state_q == ST_RUN) && (act_eff != ACT_OFF)
                    && (count_q >= tmo_a[stage_q]);

    // Stage sequencer; a stage whose action is off is skipped at once.
    always_ff @(posedge clk) begin
        if (reset || !en) begin
            state_q <= ST_IDLE;
            stage_q <= 2'h0;
            count_q <= 32'h0;
        end else if (feed) begin
            state_q <= ST_RUN;
            stage_q <= 2'h0;
            count_q <= 32'h0;
        end else begin
            case (state_q)
                ST_IDLE: state_q <= ST_RUN;
                ST_RUN: begin
                    if (act_eff == ACT_OFF || expire) begin
                        count_q <= 32'h0;
                        if (stage_q == 2'h3) begin
                            state_q <= ST_DONE;
                        end else begin
                            stage_q <= stage_q + 2'h1;
                        end
                    end else begin
                        count_q <= count_q + 32'h1;
                    end
                end
                default: state_q <= ST_DONE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            fire_q     <= 1'b0;
            fire_act_q <= ACT_OFF;
        end else begin
            fire_q     <= en && !feed && expire;
            fire_act_q <= act_eff;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_feed_restart: assert property (en && feed |=> count_q == 32'h0 && stage_q == 2'h0)
        else $error("Feed did not restart the watchdog.");
    a_fire_cause: assert property (
        fire_q |-> $past(state_q) == ST_RUN && $past(count_q) >= $past(tmo_a[stage_q]))
        else $error("Expiry fired without a timeout.");
    a_no_sys_main: assert property (!HAS_SYS && fire_q |-> fire_act_q != ACT_SYS)
        else $error("Main watchdog fired a system reset.");
    a_quiet_disabled: assert property (!en |=> !fire_q && count_q == 32'h0)
        else $error("Disabled watchdog counted or fired.");
    c_stage_next: cover property (state_q == ST_RUN && stage_q == 2'h0 ##1 stage_q == 2'h1);
    c_done: cover property (state_q == ST_DONE);
endmodule // mswd_wdt

// File: test/mswd_tb.sv
// Self-checking testbench for the four-stage watchdog block.
`timescale 1ns/1ps
`include "mswd_cfg.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, (g), (e)); end end
module tb;
    // Short boot guard so the boot scenario stays brief.
    localparam int BOOT_CYC = 50;
    logic        CLK, RESET, AVS_READ, AVS_WRITE, BOOT_FLASH;
    logic [7:0]  AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA, exp_v;
    logic [3:0]  AVS_BYTEENABLE;
    logic        AVS_WAITREQUEST, IRQ, CPU_RST_REQ, CORE_RST_REQ, SYS_RST_REQ;
    int          error_cnt, total_checks, cyc, cpu_n, core_n, sys_n, cpu_t, core_t;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'h0000001f;

    mswd_top #(.BOOT_TMO_CYC(BOOT_CYC)) dut (
        .CLK(CLK), .RESET(RESET),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
        .BOOT_FLASH(BOOT_FLASH), .IRQ(IRQ), .CPU_RST_REQ(CPU_RST_REQ),
        .CORE_RST_REQ(CORE_RST_REQ), .SYS_RST_REQ(SYS_RST_REQ)
    );

    // Clock at 200 MHz.
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end

    // Watcher: counts reset pulses and compares read data with the oldest note.
    always @(posedge CLK) begin
        cyc++;
        if (CPU_RST_REQ === 1'b1) begin
            cpu_n++;
            cpu_t = cyc;
        end
        if (CORE_RST_REQ === 1'b1) begin
            core_n++;
            core_t = cyc;
        end
        if (SYS_RST_REQ === 1'b1) sys_n++;
        if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
            if (exp_q.size() == 0) begin
                error_cnt++;
                $display("wrong value at %0t: read with no note", $time);
            end else begin
                exp_v = exp_q.pop_front();
                `CHK(AVS_READDATA, exp_v)
            end
        end
    end

    // Xorshift source; a fixed start keeps runs repeatable.
    function automatic logic [31:0] nxt();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] adr(input logic [1:0] w, input logic [5:0] off);
        return {w, off};
    endfunction

    // One bus access; the request stands until waitrequest is seen low.
    task automatic acc(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge CLK);
        n = 0;
        AVS_ADDRESS   <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE     <= is_wr;
        AVS_READ      <= ~is_wr;
        do begin
            @(posedge CLK);
            n++;
        end while (AVS_WAITREQUEST !== 1'b0 && n < 40);
        if (n >= 40) begin
            error_cnt++;
            $display("wrong value at %0t: bus access hung", $time);
        end
        AVS_WRITE <= 1'b0;
        AVS_READ  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        acc(1'b0, a, 32'h00000000);
    endtask

    // Waits a bounded time for a pulse counter to move.
    task automatic wait_cnt(ref int cnt, input int base, input int lim);
        int k;
        k = 0;
        while (cnt == base && k < lim) begin
            @(posedge CLK);
            k++;
        end
    endtask

    task automatic endt(input string name);
        $display("test %s finished at %0t", name, $time);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Hang guard; the whole sequence needs well under this many cycles.
    initial begin
        repeat (20000) @(posedge CLK);
        error_cnt++;
        $display("wrong value at %0t: run timed out", $time);
        wrap_up();
    end

    // Main sequence.
    initial begin
        logic [31:0] r;
        int c0, c1;
        RESET = 1'b1;
        BOOT_FLASH = 1'b1;
        AVS_READ = 1'b0;
        AVS_WRITE = 1'b0;
        AVS_ADDRESS = 8'h00;
        AVS_WRITEDATA = 32'h00000000;
        AVS_BYTEENABLE = 4'hf;
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        repeat (6) @(posedge CLK);
        rd(adr(2'h0, `MSWD_OFF_CFG), 32'h00000007);
        rd(adr(2'h2, `MSWD_OFF_CFG), 32'h00000009);
        rd(adr(2'h2, `MSWD_OFF_TMO0), 32'(BOOT_CYC));
        wait_cnt(sys_n, 0, 200);
        `CHK(sys_n, 1)
        `CHK(core_n, 1)
        BOOT_FLASH <= 1'b0;
        repeat (3) @(posedge CLK);
        RESET <= 1'b1;
        repeat (5) @(posedge CLK);
        RESET <= 1'b0;
        endt("boot guard");
        rd(adr(2'h1, `MSWD_OFF_CFG), 32'h00000000);
        rd(adr(2'h1, `MSWD_OFF_TMO3), `MSWD_TMO_RST);
        rd(adr(2'h1, `MSWD_OFF_PROT), 32'h00000001);
        rd(8'hcc, 32'h00000000);
        c0 = sys_n + core_n + cpu_n;
        repeat (120) @(posedge CLK);
        `CHK(sys_n + core_n + cpu_n, c0)
        wr(adr(2'h1, `MSWD_OFF_CFG), 32'h00000003);
        rd(adr(2'h1, `MSWD_OFF_CFG), 32'h00000000);
        wr(adr(2'h1, `MSWD_OFF_TMO0), 32'h00000011);
        rd(adr(2'h1, `MSWD_OFF_TMO0), `MSWD_TMO_RST);
        wr(adr(2'h1, `MSWD_OFF_PROT), `MSWD_UNLOCK_KEY);
        rd(adr(2'h1, `MSWD_OFF_PROT), 32'h00000000);
        wr(adr(2'h1, `MSWD_OFF_PROT), 32'h00001234);
        rd(adr(2'h1, `MSWD_OFF_PROT), 32'h00000001);
        for (int w = 0; w < 3; w++) wr(adr(2'(w), `MSWD_OFF_PROT), `MSWD_UNLOCK_KEY);
        r = nxt();
        wr(adr(2'h1, `MSWD_OFF_TMO0 + 6'h08), r);
        rd(adr(2'h1, `MSWD_OFF_TMO0 + 6'h08), r);
        AVS_BYTEENABLE <= 4'h3;
        wr(adr(2'h1, `MSWD_OFF_TMO0 + 6'h08), ~r);
        AVS_BYTEENABLE <= 4'hf;
        rd(adr(2'h1, `MSWD_OFF_TMO0 + 6'h08), {r[31:16], ~r[15:0]});
        endt("protection");
        r = nxt();
        wr(8'hc4, 32'h00000001);
        wr(adr(2'h0, `MSWD_OFF_TMO0), 32'h00000004 + {29'h0, r[2:0]});
        wr(adr(2'h0, `MSWD_OFF_CFG), 32'h00000003);
        c0 = 0;
        while (IRQ !== 1'b1 && c0 < 60) begin
            @(posedge CLK);
            c0++;
        end
        `CHK(IRQ, 1'b1)
        rd(8'hc0, 32'h00000001);
        wr(8'hc8, 32'h00000001);
        repeat (3) @(posedge CLK);
        `CHK(IRQ, 1'b0)
        rd(8'hc0, 32'h00000000);
        wr(adr(2'h0, `MSWD_OFF_CFG), 32'h00000000);
        endt("interrupt");
        for (int s = 0; s < 4; s++) begin
            r = nxt();
            wr(adr(2'h1, `MSWD_OFF_TMO0 + 6'(4 * s)), 32'h00000004 + {29'h0, r[2:0]});
        end
        c0 = cpu_n;
        c1 = core_n;
        wr(adr(2'h1, `MSWD_OFF_CFG), 32'h000005a1);
        wait_cnt(core_n, c1, 200);
        `CHK(cpu_n, c0 + 1)
        `CHK(core_n, c1 + 1)
        `CHK(cpu_t < core_t, 1'b1)
        repeat (30) @(posedge CLK);
        `CHK(IRQ, 1'b0)
        rd(8'hc0, 32'h00000002);
        wr(8'hc4, 32'h00000003);
        repeat (3) @(posedge CLK);
        `CHK(IRQ, 1'b1)
        wr(8'hc8, 32'h00000002);
        wr(adr(2'h1, `MSWD_OFF_CFG), 32'h00000000);
        endt("stage order");
        wr(adr(2'h1, `MSWD_OFF_TMO0), 32'h00000028);
        c0 = cpu_n;
        wr(adr(2'h1, `MSWD_OFF_CFG), 32'h00000005);
        repeat (6) begin
            repeat (20) @(posedge CLK);
            wr(adr(2'h1, `MSWD_OFF_FEED), 32'h00000001);
        end
        `CHK(cpu_n, c0)
        wait_cnt(cpu_n, c0, 100);
        `CHK(cpu_n, c0 + 1)
        wr(adr(2'h1, `MSWD_OFF_CFG), 32'h00000000);
        endt("feed");
        c0 = sys_n;
        wr(adr(2'h0, `MSWD_OFF_TMO0), 32'h00000005);
        wr(adr(2'h0, `MSWD_OFF_CFG), 32'h00000009);
        repeat (40) @(posedge CLK);
        `CHK(sys_n, c0)
        wr(adr(2'h2, `MSWD_OFF_TMO0), 32'h00000005);
        wr(adr(2'h2, `MSWD_OFF_CFG), 32'h00000009);
        wait_cnt(sys_n, c0, 60);
        `CHK(sys_n, c0 + 1)
        rd(adr(2'h2, `MSWD_OFF_STAT), 32'h0000000b);
        wr(adr(2'h2, `MSWD_OFF_CFG), 32'h00000000);
        wr(adr(2'h2, `MSWD_OFF_TMO0), 32'h0000001e);
        wr(adr(2'h2, `MSWD_OFF_CFG), 32'h00000009);
        repeat (10) @(posedge CLK);
        wr(adr(2'h2, `MSWD_OFF_CFG), 32'h00000000);
        rd(adr(2'h2, `MSWD_OFF_CNT), 32'h00000000);
        repeat (60) @(posedge CLK);
        `CHK(sys_n, c0 + 1)
        endt("system action");
        wrap_up();
    end
endmodule // tb
